// File: hdl/dws_acquire.sv
// Dword synchronization acquisition with K28.5 alignment and connection gating
//
// Contract
// [RQ1] After OOB or loss of signal in sync, enter acquire start, disable connection fsm.
// [RQ2] In acquire start, first K28.5 seen is placed in byte position zero.
// [RQ3] In acquire start, realign on every K28.5 until a valid primitive decodes.
// [RQ4] Acquire start moves to one-valid on a valid primitive.
// [RQ5] Acquire start stays put on a valid non-primitive dword.
// [RQ6] Acquire start stays put on invalid dword or loss, still realigning.
// [RQ7] One-valid moves to two-valid on another valid primitive.
// [RQ8] One-valid stays put on a valid non-primitive dword.
// [RQ9] One-valid returns to acquire start on invalid dword or loss.
// [RQ10] Two-valid moves to sync-acquired on a further valid primitive.
// [RQ11] Two-valid stays put on a valid non-primitive dword.
// [RQ12] Two-valid returns to acquire start on invalid dword or loss.
// [RQ13] Sync-acquired enables connection fsm and forwards the current primitive.
// [RQ14] Without sync, received data is not forwarded to the connection fsm.
// [RQ15] Sync-acquired stays put on a valid dword.
// [RQ16] Sync-acquired moves to first lose-sync stage on an invalid dword.
// [RQ17] Sync-acquired returns to acquire start on loss of signal.
// [RQ18] Reset starts in acquire start, connection fsm off, no alignment.
`timescale 1ns/1ps
`include "dws_cfg.svh"

module dws_acquire
  import dws_pkg::*;
#(
  parameter int SYM_W = `DWS_SYM_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sym_valid,
  input wire logic [SYM_W-1:0] sym_data,
  input wire logic oob_done,
  input wire logic loss_of_signal,
  input wire logic verdict_valid,
  input wire dws_verdict_s verdict,
  output logic dword_out_valid_reg,
  output dws_dword_t dword_out_reg,
  output logic align_valid_reg,
  output logic [1:0] lane_reg,
  output logic conn_enable_reg,
  output logic fwd_valid_reg,
  output dws_state_e state_reg
);

  logic los_s1, los_s2, los_s3;
  logic [SYM_W*3-1:0] shift_reg;
  logic [1:0] lane_next;
  logic is_k285;
  logic realign;
  logic lose_sync;
  dws_state_e state_next;
  logic [1:0] lose_cnt_reg;
  logic los_evt;
  logic ev_prim, ev_data, ev_bad;

  // Loss of signal comes from the analog detector, so it is synchronised
  always_ff @(posedge mclk) begin
    if (rst) begin
      los_s1 <= 1'b1;
      los_s2 <= 1'b1;
      los_s3 <= 1'b1;
    end else begin
      los_s1 <= loss_of_signal;
      los_s2 <= los_s1;
      los_s3 <= los_s2;
    end
  end

  // A change counts only once the second and third stages agree
  logic los_level_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      los_level_reg <= 1'b1;
    end else if (los_s2 == los_s3) begin
      los_level_reg <= los_s3;
    end
  end

  assign los_evt = los_level_reg;
  assign is_k285 = sym_valid && (sym_data == SYM_W'(`DWS_K285_RD_NEG) || sym_data == SYM_W'(`DWS_K285_RD_POS));
  assign realign = (state_reg == DWS_ACQ_START) && is_k285; // [RQ2] [RQ3] [RQ6]
  assign ev_prim = verdict_valid && !los_evt && verdict.prim_valid && !verdict.dword_invalid;
  assign ev_data = verdict_valid && !los_evt && verdict.dword_valid && !verdict.prim_valid && !verdict.dword_invalid;
  assign ev_bad = los_evt || (verdict_valid && verdict.dword_invalid);
  assign lose_sync = (lose_cnt_reg == 2'(`DWS_LOS_SYNC_STAGES - 1));

  // Symbol lane counter: K28.5 forces lane zero while acquiring
  always_comb begin
    lane_next = lane_reg;
    if (sym_valid) begin
      if (realign) begin
        lane_next = 2'h1; // [RQ2] [RQ3]
      end else begin
        lane_next = lane_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lane_reg <= 2'h0;
      shift_reg <= '0;
      dword_out_reg <= '0;
      dword_out_valid_reg <= 1'b0;
      align_valid_reg <= 1'b0; // [RQ18]
    end else begin
      lane_reg <= lane_next;
      dword_out_valid_reg <= 1'b0;
      // Cleared first so that a comma arriving with the OOB pulse while already in acquire start still sets alignment
      if (oob_done) begin
        align_valid_reg <= 1'b0;
      end
      if (sym_valid) begin
        if (realign) begin
          shift_reg <= {{(SYM_W*2){1'b0}}, sym_data};
          align_valid_reg <= 1'b1;
        end else if (lane_reg == 2'h3) begin
          dword_out_reg <= {shift_reg, sym_data};
          dword_out_valid_reg <= align_valid_reg;
        end else begin
          shift_reg <= {shift_reg[SYM_W*2-1:0], sym_data};
        end
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DWS_ACQ_START: begin
        if (ev_prim) begin
          state_next = DWS_ONE_VALID; // [RQ4]
        end else begin
          state_next = DWS_ACQ_START; // [RQ5] [RQ6]
        end
      end
      DWS_ONE_VALID: begin
        if (ev_bad) begin
          state_next = DWS_ACQ_START; // [RQ9]
        end else if (ev_prim) begin
          state_next = DWS_TWO_VALID; // [RQ7]
        end else begin
          state_next = DWS_ONE_VALID; // [RQ8]
        end
      end
      DWS_TWO_VALID: begin
        if (ev_bad) begin
          state_next = DWS_ACQ_START; // [RQ12]
        end else if (ev_prim) begin
          state_next = DWS_SYNC_ACQ; // [RQ10]
        end else begin
          state_next = DWS_TWO_VALID; // [RQ11]
        end
      end
      DWS_SYNC_ACQ: begin
        if (los_evt) begin
          state_next = DWS_ACQ_START; // [RQ17] [RQ1]
        end else if (ev_bad) begin
          state_next = DWS_LOSE1; // [RQ16]
        end else begin
          state_next = DWS_SYNC_ACQ; // [RQ15]
        end
      end
      // Lose-sync stages: invalid deepens, two valids step back one level
      DWS_LOSE1: begin
        if (los_evt || (ev_bad && lose_sync)) begin
          state_next = DWS_ACQ_START;
        end else if (ev_bad) begin
          state_next = DWS_LOSE2;
        end else if (ev_prim || ev_data) begin
          state_next = DWS_LOSE1_VAL;
        end
      end
      DWS_LOSE1_VAL: begin
        if (los_evt || (ev_bad && lose_sync)) begin
          state_next = DWS_ACQ_START;
        end else if (ev_bad) begin
          state_next = DWS_LOSE2;
        end else if (ev_prim || ev_data) begin
          state_next = (lose_cnt_reg == 2'h0) ? DWS_SYNC_ACQ : DWS_LOSE1;
        end
      end
      DWS_LOSE2: begin
        if (los_evt || (ev_bad && lose_sync)) begin
          state_next = DWS_ACQ_START;
        end else if (ev_bad) begin
          state_next = DWS_LOSE2;
        end else if (ev_prim || ev_data) begin
          state_next = DWS_LOSE2_VAL;
        end
      end
      DWS_LOSE2_VAL: begin
        if (los_evt || (ev_bad && lose_sync)) begin
          state_next = DWS_ACQ_START;
        end else if (ev_bad) begin
          state_next = DWS_LOSE2;
        end else if (ev_prim || ev_data) begin
          state_next = DWS_LOSE1;
        end
      end
      default: begin
        state_next = DWS_ACQ_START;
      end
    endcase
    if (oob_done) begin
      state_next = DWS_ACQ_START; // [RQ1]
    end
  end

  // Depth of the lose-sync ladder: 0 for first stage, up to 2 for third
  logic [1:0] lose_cnt_next;
  always_comb begin
    lose_cnt_next = lose_cnt_reg;
    if (state_next == DWS_ACQ_START || state_next == DWS_SYNC_ACQ) begin
      lose_cnt_next = 2'h0;
    end else if (state_reg != DWS_SYNC_ACQ && ev_bad && !los_evt && (state_next == DWS_LOSE2)) begin
      lose_cnt_next = lose_cnt_reg + 2'h1;
    end else if ((state_reg == DWS_LOSE1_VAL || state_reg == DWS_LOSE2_VAL) && state_next == DWS_LOSE1
                 && lose_cnt_reg != 2'h0) begin
      lose_cnt_next = lose_cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= DWS_ACQ_START; // [RQ18]
      lose_cnt_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      lose_cnt_reg <= lose_cnt_next;
    end
  end

  // Enable is held through lose-sync stages since alignment may still be good
  always_ff @(posedge mclk) begin
    if (rst) begin
      conn_enable_reg <= 1'b0; // [RQ18]
      fwd_valid_reg <= 1'b0;
    end else begin
      conn_enable_reg <= (state_next != DWS_ACQ_START) && (state_next != DWS_ONE_VALID)
                         && (state_next != DWS_TWO_VALID); // [RQ1] [RQ13]
      // The third primitive itself is forwarded on the acquiring transition
      // OOB wins: nothing is forwarded on the cycle the link restarts acquisition
      fwd_valid_reg <= !oob_done && ((state_reg == DWS_TWO_VALID && ev_prim)
                       || (state_reg == DWS_SYNC_ACQ && (ev_prim || ev_data))); // [RQ13] [RQ14]
    end
  end

endmodule

// File: hdl/dws_cfg.svh
// Constants for the dword synchronization acquisition block
`ifndef DWS_CFG_SVH
`define DWS_CFG_SVH
`define DWS_K285_RD_NEG 10'h17c
`define DWS_K285_RD_POS 10'h283
`define DWS_SYMS_PER_DWORD 4
`define DWS_SYM_W 10
`define DWS_LOS_SYNC_STAGES 3
`endif

// File: hdl/dws_pkg.sv
// Types for the dword synchronization acquisition block
package dws_pkg;
  // Gray coded along acquire -> one -> two -> acquired -> lose stages
  typedef enum logic [2:0] {
    DWS_ACQ_START = 3'h0,
    DWS_ONE_VALID = 3'h1,
    DWS_TWO_VALID = 3'h3,
    DWS_SYNC_ACQ  = 3'h2,
    DWS_LOSE1     = 3'h6,
    DWS_LOSE1_VAL = 3'h7,
    DWS_LOSE2     = 3'h5,
    DWS_LOSE2_VAL = 3'h4
  } dws_state_e;

  // Per-dword verdict from the decoder
  typedef struct packed {
    logic prim_valid;
    logic dword_valid;
    logic dword_invalid;
  } dws_verdict_s;

  typedef logic [39:0] dws_dword_t;
endpackage

// File: test/dws_acquire_sva.sv
// Assertion checker for the dword sync acquisition block
`timescale 1ns/1ps
module dws_acquire_chk
  import dws_pkg::*;
#(parameter int SYM_W = 10) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sym_valid,
  input wire logic [SYM_W-1:0] sym_data,
  input wire logic oob_done,
  input wire logic loss_of_signal,
  input wire logic verdict_valid,
  input wire dws_verdict_s verdict,
  input wire logic dword_out_valid_reg,
  input wire dws_dword_t dword_out_reg,
  input wire logic align_valid_reg,
  input wire logic [1:0] lane_reg,
  input wire logic conn_enable_reg,
  input wire logic fwd_valid_reg,
  input wire dws_state_e state_reg
);
  // Loss passes a synchronizer, so verdicts count only after a clean run
  logic [2:0] clean_reg;
  always_ff @(posedge mclk) begin
    if (rst || loss_of_signal) clean_reg <= 3'h0;
    else if (clean_reg != 3'h7) clean_reg <= clean_reg + 3'h1;
  end
  wire logic ok = verdict_valid && !oob_done && clean_reg > 3'h5;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence prim_s; ok && verdict.prim_valid && !verdict.dword_invalid; endsequence
  sequence data_s; ok && verdict.dword_valid && !verdict.prim_valid && !verdict.dword_invalid; endsequence
  sequence bad_s; ok && verdict.dword_invalid; endsequence
  acq_to_one_a: assert property (state_reg == DWS_ACQ_START ##0 prim_s |=> state_reg == DWS_ONE_VALID)
    else $error("no step to one-valid");
  one_to_two_a: assert property (state_reg == DWS_ONE_VALID ##0 prim_s |=> state_reg == DWS_TWO_VALID)
    else $error("no step to two-valid");
  sync_entry_a: assert property (state_reg == DWS_TWO_VALID ##0 prim_s |=> state_reg == DWS_SYNC_ACQ
    && conn_enable_reg && fwd_valid_reg) else $error("sync entry wrong");
  stay_data_a: assert property (state_reg inside {DWS_ACQ_START, DWS_ONE_VALID, DWS_TWO_VALID}
    ##0 data_s |=> $stable(state_reg)) else $error("data dword moved state");
  drop_bad_a: assert property (state_reg inside {DWS_ONE_VALID, DWS_TWO_VALID} ##0 bad_s
    |=> state_reg == DWS_ACQ_START) else $error("bad dword kept stage");
  sync_hold_a: assert property (state_reg == DWS_SYNC_ACQ ##0 data_s |=> state_reg == DWS_SYNC_ACQ)
    else $error("sync not held");
  sync_lose_a: assert property (state_reg == DWS_SYNC_ACQ ##0 bad_s |=> state_reg == DWS_LOSE1)
    else $error("no first lose stage");
  gate_off_a: assert property (state_reg inside {DWS_ACQ_START, DWS_ONE_VALID, DWS_TWO_VALID}
    |-> !conn_enable_reg && !fwd_valid_reg) else $error("forwarded while unsynced");
  loss_drop_a: assert property (loss_of_signal [*7] |-> state_reg == DWS_ACQ_START && !conn_enable_reg)
    else $error("loss did not restart");
  oob_drop_a: assert property (oob_done |=> state_reg == DWS_ACQ_START && !conn_enable_reg)
    else $error("oob did not restart");
  k_align_a: assert property (state_reg == DWS_ACQ_START && sym_valid
    && sym_data inside {10'h17c, 10'h283} |=> lane_reg == 2'h1 && align_valid_reg)
    else $error("comma not put at lane zero");
  reset_a: assert property ($past(rst) |-> state_reg == DWS_ACQ_START && !conn_enable_reg
    && !align_valid_reg) else $error("reset state wrong");
endmodule
bind dws_acquire dws_acquire_chk #(.SYM_W(SYM_W)) chk_u (.mclk(mclk), .rst(rst), .sym_valid(sym_valid),
  .sym_data(sym_data), .oob_done(oob_done), .loss_of_signal(loss_of_signal), .verdict_valid(verdict_valid),
  .verdict(verdict), .dword_out_valid_reg(dword_out_valid_reg), .dword_out_reg(dword_out_reg),
  .align_valid_reg(align_valid_reg), .lane_reg(lane_reg), .conn_enable_reg(conn_enable_reg),
  .fwd_valid_reg(fwd_valid_reg), .state_reg(state_reg));

// File: test/dws_link_model.sv
// Model of the attached transmitter with its decoder verdicts
`timescale 1ns/1ps
module dws_link_model
  import dws_pkg::*;
(
  input wire logic mclk,
  output logic sym_valid,
  output logic [9:0] sym_data,
  output logic verdict_valid,
  output dws_verdict_s verdict
);
  initial begin
    sym_valid = 1'b0;
    sym_data = 10'h0;
    verdict_valid = 1'b0;
    verdict = '0;
  end
  // First symbol first; the verdict rides with the last symbol
  task automatic send(input dws_dword_t dw, input dws_verdict_s v);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      sym_valid <= 1'b1;
      sym_data <= dw[39-10*i -: 10];
      verdict_valid <= (i == 3);
      verdict <= v;
    end
    @(posedge mclk);
    sym_valid <= 1'b0;
    sym_data <= ~sym_data;
    verdict_valid <= 1'b0;
    verdict <= ~v;
  endtask
endmodule

// File: test/test_dws_acquire.sv
// Self-checking testbench for the dword sync acquisition block
`timescale 1ns/1ps
`include "dws_cfg.svh"
module test_dws_acquire
  import dws_pkg::*;
;
  logic mclk, rst, oob_done, loss_of_signal, sym_valid, verdict_valid;
  logic [9:0] sym_data;
  dws_verdict_s verdict;
  logic dword_out_valid_reg, align_valid_reg, conn_enable_reg, fwd_valid_reg;
  dws_dword_t dword_out_reg;
  logic [1:0] lane_reg;
  dws_state_e state_reg;
  int num_errors, checks;
  localparam dws_dword_t KDW = {`DWS_K285_RD_NEG, 10'h2aa, 10'h155, 10'h0f0};
  localparam dws_verdict_s PRIM = 3'h6, DATA = 3'h2, BAD = 3'h1;
  dws_link_model link_u (.mclk(mclk), .sym_valid(sym_valid), .sym_data(sym_data),
    .verdict_valid(verdict_valid), .verdict(verdict));
  dws_acquire dut_u (.mclk(mclk), .rst(rst), .sym_valid(sym_valid), .sym_data(sym_data), .oob_done(oob_done),
    .loss_of_signal(loss_of_signal), .verdict_valid(verdict_valid), .verdict(verdict),
    .dword_out_valid_reg(dword_out_valid_reg), .dword_out_reg(dword_out_reg), .align_valid_reg(align_valid_reg),
    .lane_reg(lane_reg), .conn_enable_reg(conn_enable_reg), .fwd_valid_reg(fwd_valid_reg), .state_reg(state_reg));
  always #12.5 mclk = ~mclk;
  task check(input logic [39:0] seen, input logic [39:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task go(input dws_verdict_s v, input dws_state_e s);
    link_u.send(KDW, v);
    #1;
    check(40'(state_reg), 40'(s));
    check(40'(dword_out_valid_reg), 40'h1);
  endtask
  task t_reset;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    check({conn_enable_reg, align_valid_reg, state_reg}, {2'b00, DWS_ACQ_START});
    $display("t_reset done");
  endtask
  task t_climb;
    go(DATA, DWS_ACQ_START);
    check(40'(dword_out_reg[39:30]), 40'(`DWS_K285_RD_NEG));
    // Comma in the second slot: realignment must leave no dword at the old boundary
    link_u.send({10'h2aa, `DWS_K285_RD_POS, 10'h155, 10'h0f0}, DATA);
    #1;
    check(40'({dword_out_valid_reg, lane_reg}), 40'h3);
    go(BAD, DWS_ACQ_START);
    go(PRIM, DWS_ONE_VALID);
    go(DATA, DWS_ONE_VALID);
    go(BAD, DWS_ACQ_START);
    go(PRIM, DWS_ONE_VALID);
    go(PRIM, DWS_TWO_VALID);
    go(DATA, DWS_TWO_VALID);
    go(BAD, DWS_ACQ_START);
    go(PRIM, DWS_ONE_VALID);
    go(PRIM, DWS_TWO_VALID);
    go(PRIM, DWS_SYNC_ACQ);
    check({conn_enable_reg, fwd_valid_reg}, 2'b11);
    $display("t_climb done");
  endtask
  task t_exit;
    go(DATA, DWS_SYNC_ACQ);
    go(BAD, DWS_LOSE1);
    go(DATA, DWS_LOSE1_VAL);
    go(PRIM, DWS_SYNC_ACQ);
    check(40'(conn_enable_reg), 40'h1);
    @(posedge mclk);
    loss_of_signal <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    check({conn_enable_reg, state_reg}, {1'b0, DWS_ACQ_START});
    @(posedge mclk);
    loss_of_signal <= 1'b0;
    repeat (8) @(posedge mclk);
    $display("t_exit done");
  endtask
  task t_oob;
    repeat (3) link_u.send(KDW, PRIM);
    #1;
    check({conn_enable_reg, state_reg}, {1'b1, DWS_SYNC_ACQ});
    @(posedge mclk);
    oob_done <= 1'b1;
    @(posedge mclk);
    oob_done <= 1'b0;
    #1;
    check({conn_enable_reg, state_reg}, {1'b0, DWS_ACQ_START});
    $display("t_oob done");
  endtask
  // Tests need about 140 cycles; the 4000-cycle watchdog margin covers a hung test
  initial begin
    #(25 * 4000);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    oob_done = 1'b0;
    loss_of_signal = 1'b0;
    t_reset;
    t_climb;
    t_exit;
    t_oob;
    tally_and_finish;
  end
endmodule
